// ---- rtl/uafd_pkg.sv ----
// Purpose: shared constants and types of the address filtering serial port
// Assumes: one system clock, register port with 3-bit word index
// Notes: register layout of status, control, format and baud words
package uafd_pkg;
  // ----------------------------------------------------------------
  // register index
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_STAT = 3'h1;
  localparam logic [2:0] OFS_CTRL = 3'h2;
  localparam logic [2:0] OFS_FMT = 3'h3;
  localparam logic [2:0] OFS_BAUD_LO = 3'h4;
  localparam logic [2:0] OFS_BAUD_HI = 3'h5;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ST_RX_DONE = 7;
  localparam int ST_TX_DONE = 6;
  localparam int ST_TX_EMPTY = 5;
  localparam int ST_FRAME_ERR = 4;
  localparam int ST_OVERRUN = 3;
  localparam int ST_PARITY_ERR = 2;
  localparam int ST_DOUBLE = 1;
  localparam int ST_FILTER = 0;
  localparam int CT_RX_EN = 4;
  localparam int CT_TX_EN = 3;
  localparam int CT_SIZE2 = 2;
  localparam int CT_RX9 = 1;
  localparam int CT_TX9 = 0;
  localparam int FM_PAR_EN = 5;
  localparam int FM_PAR_ODD = 4;
  localparam int FM_STOP2 = 3;
  localparam int FM_SIZE_HI = 2;
  localparam int FM_SIZE_LO = 1;
  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] FMT_RESET = 8'h06;
  localparam logic [2:0] SIZE_NINE = 3'h7;
  // ----------------------------------------------------------------
  // receiver sampling
  // ----------------------------------------------------------------
  localparam logic [4:0] SPB_NORMAL = 5'h10;
  localparam logic [4:0] SPB_DOUBLE = 5'h08;
  localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
  localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
  localparam logic [4:0] VOTE_MID_NORMAL = 5'h09;
  localparam logic [4:0] VOTE_MID_DOUBLE = 5'h05;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_BITS = 2'b10,
    RX_STOP = 2'b11
  } uafd_rx_state_t;
endpackage

// ---- rtl/uafd_top.sv ----
// Purpose: serial port slice with address frame filter and shared data word
// Assumes: registers reached over a plain strobe port, read data next cycle
// Notes: interrupts, sync and spi modes are not part of this slice
//
// Summary of operation
// - filter on: frames without address marking are dropped, never queued
// - five to eight data bits: first stop bit is the frame type
// - nine data bits: received ninth bit is the frame type
// - type one means address frame, type zero means data frame
// - transmitter ignores the filter enable bit
// - accepted address frame raises receive done like any frame
// - one data word: writes feed transmit buffer, reads give receive head
// - short characters: upper written bits ignored, read back as zero
// - data write while transmit buffer full is ignored
// - buffered data moves to empty shifter when enabled, then shifts out
// - receive buffer is two-entry queue, each data read pops it
// - sixteen samples per bit normal, eight in double speed
// - voting starts at sample 8 or 4, middle sample 9 or 5
// - keep baud error near 2.0 or 1.5 percent per end
// - receive done set while queue holds data, clear when empty
// - transmit empty flag high when buffer free, set after reset
`timescale 1ns/100ps
`default_nettype none
module uafd_top (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic [2:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic SERIAL_IN_PIN_I,
  output logic [7:0] RDATA_O,
  output logic SERIAL_OUT_PIN_O
);
  import uafd_pkg::*;

  // ----------------------------------------------------------------
  // configuration and shared decode
  // ----------------------------------------------------------------
  logic filter_en, dbl, rx_en, tx_en, size2, tx9, tx_done, overrun, tx_valid;
  logic [7:0] fmt;
  logic [11:0] baud_div, baud_cnt;
  logic [2:0] size;
  logic [3:0] nb;
  logic [4:0] spb, vfirst, vmid, vlast;
  logic nine, tick, wr_data, pop;
  assign size = {size2, fmt[FM_SIZE_HI], fmt[FM_SIZE_LO]};
  assign nine = (size == SIZE_NINE);
  assign wr_data = WR_I && ADDR_I == OFS_DATA;
  assign pop = RD_I && ADDR_I == OFS_DATA;
  // rate error of the divisor is the user's budget, split with the far end
  assign tick = (baud_cnt == 12'h000);
  // sample rate and vote points follow the speed select
  assign spb = dbl ? SPB_DOUBLE : SPB_NORMAL;
  assign vfirst = dbl ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL;
  assign vmid = dbl ? VOTE_MID_DOUBLE : VOTE_MID_NORMAL;
  assign vlast = vmid + 5'h01;
  always_comb begin
    unique case (size)
      3'h0: nb = 4'h5;
      3'h1: nb = 4'h6;
      3'h2: nb = 4'h7;
      3'h7: nb = 4'h9;
      default: nb = 4'h8;
    endcase
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  uafd_rx_state_t rx_state, next_rx_state;
  logic rx_s1, rx_s2, rx_par, next_rx_par, maj, rx_end, rx_type, drop;
  logic [4:0] rx_smp, next_rx_smp;
  logic [3:0] rx_idx, next_rx_idx, rx_last;
  logic [1:0] rx_v, next_rx_v;
  logic [8:0] rx_sh, next_rx_sh;
  assign rx_last = nb + {3'h0, fmt[FM_PAR_EN]} - 4'h1;
  assign maj = (rx_v[1] & rx_v[0]) | (rx_v[1] & rx_s2) | (rx_v[0] & rx_s2);
  assign rx_type = nine ? rx_sh[8] : maj;
  assign drop = rx_end && filter_en && !rx_type;
  always_comb begin
    next_rx_state = rx_state;
    next_rx_smp = rx_smp;
    next_rx_idx = rx_idx;
    next_rx_v = rx_v;
    next_rx_sh = rx_sh;
    next_rx_par = rx_par;
    rx_end = 1'b0;
    if (!rx_en) begin
      next_rx_state = RX_IDLE;
    end else if (tick) begin
      if (rx_state == RX_IDLE) begin
        if (!rx_s2) begin
          next_rx_state = RX_START;
          next_rx_smp = 5'h01;
          next_rx_sh = 9'h000;
        end
      end else begin
        next_rx_smp = (rx_smp == spb) ? 5'h01 : rx_smp + 5'h01;
        if (rx_smp == vfirst || rx_smp == vmid) begin
          next_rx_v = {rx_v[0], rx_s2};
        end
        if (rx_smp == vlast) begin
          if (rx_state == RX_START && maj) begin
            next_rx_state = RX_IDLE;
          end
          if (rx_state == RX_BITS) begin
            if (rx_idx < nb) begin
              next_rx_sh[rx_idx] = maj;
            end else begin
              next_rx_par = maj;
            end
          end
          if (rx_state == RX_STOP) begin
            // ends at the vote so an early next start bit is seen
            rx_end = 1'b1;
            next_rx_state = RX_IDLE;
          end
        end
        if (rx_smp == spb) begin
          if (rx_state == RX_START) begin
            next_rx_state = RX_BITS;
            next_rx_idx = 4'h0;
          end else if (rx_state == RX_BITS) begin
            if (rx_idx == rx_last) begin
              next_rx_state = RX_STOP;
            end else begin
              next_rx_idx = rx_idx + 4'h1;
            end
          end
        end
      end
    end
  end
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      rx_state <= RX_IDLE;
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_smp <= 5'h00;
      rx_idx <= 4'h0;
      rx_v <= 2'h0;
      rx_sh <= 9'h000;
      rx_par <= 1'b0;
    end else if (CE_I) begin
      rx_state <= next_rx_state;
      rx_s1 <= SERIAL_IN_PIN_I;
      rx_s2 <= rx_s1;
      rx_smp <= next_rx_smp;
      rx_idx <= next_rx_idx;
      rx_v <= next_rx_v;
      rx_sh <= next_rx_sh;
      rx_par <= next_rx_par;
    end
  end

  // ----------------------------------------------------------------
  // receive queue, registers and read port
  // ----------------------------------------------------------------
  logic [10:0] fifo_mem [2];
  logic [10:0] next_fifo_mem [2];
  logic [10:0] head;
  logic [1:0] rx_count, next_rx_count;
  logic rd_ptr, next_rd_ptr, pe, push, do_pop;
  logic next_filter_en, next_dbl, next_rx_en, next_tx_en, next_size2, next_tx9;
  logic next_overrun;
  logic [7:0] next_fmt, next_rdata;
  logic [11:0] next_baud_div, next_baud_cnt;
  assign head = fifo_mem[rd_ptr];
  assign pe = fmt[FM_PAR_EN] & (^rx_sh ^ rx_par ^ fmt[FM_PAR_ODD]);
  assign push = rx_end && !drop && rx_count != 2'h2;
  assign do_pop = pop && rx_count != 2'h0;
  always_comb begin
    next_fifo_mem = fifo_mem;
    next_rx_count = rx_count;
    next_rd_ptr = rd_ptr;
    next_overrun = overrun;
    next_filter_en = filter_en;
    next_dbl = dbl;
    next_rx_en = rx_en;
    next_tx_en = tx_en;
    next_size2 = size2;
    next_tx9 = tx9;
    next_fmt = fmt;
    next_baud_div = baud_div;
    next_baud_cnt = tick ? baud_div : baud_cnt - 12'h001;
    next_rdata = 8'h00;
    // reading the data word pops the head
    if (do_pop) begin
      next_rd_ptr = ~rd_ptr;
      next_rx_count = rx_count - 2'h1;
      next_overrun = 1'b0;
    end
    // only accepted frames touch the queue and its flags
    if (push) begin
      next_fifo_mem[rd_ptr ^ rx_count[0]] = {pe, ~maj, rx_sh};
      next_rx_count = next_rx_count + 2'h1;
      next_overrun = 1'b0;
    end else if (rx_end && !drop) begin
      next_overrun = 1'b1;
    end
    if (WR_I) begin
      unique case (ADDR_I)
        OFS_STAT: begin
          next_filter_en = WDATA_I[ST_FILTER];
          next_dbl = WDATA_I[ST_DOUBLE];
        end
        OFS_CTRL: begin
          next_rx_en = WDATA_I[CT_RX_EN];
          next_tx_en = WDATA_I[CT_TX_EN];
          next_size2 = WDATA_I[CT_SIZE2];
          next_tx9 = WDATA_I[CT_TX9];
        end
        OFS_FMT: next_fmt = WDATA_I;
        OFS_BAUD_LO: next_baud_div[7:0] = WDATA_I;
        OFS_BAUD_HI: next_baud_div[11:8] = WDATA_I[3:0];
        default: ;
      endcase
    end
    if (RD_I) begin
      unique case (ADDR_I)
        OFS_DATA: next_rdata = head[7:0];
        OFS_STAT: next_rdata = {rx_count != 2'h0, tx_done, !tx_valid,
          head[9], overrun, head[10], dbl, filter_en};
        OFS_CTRL: next_rdata = {3'h0, rx_en, tx_en, size2, head[8], tx9};
        OFS_FMT: next_rdata = fmt;
        OFS_BAUD_LO: next_rdata = baud_div[7:0];
        OFS_BAUD_HI: next_rdata = {4'h0, baud_div[11:8]};
        default: next_rdata = 8'h00;
      endcase
    end
    // disabling the receiver flushes the queue
    if (!rx_en) begin
      next_rx_count = 2'h0;
      next_overrun = 1'b0;
    end
  end
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      fifo_mem[0] <= 11'h000;
      fifo_mem[1] <= 11'h000;
      rx_count <= 2'h0;
      rd_ptr <= 1'b0;
      overrun <= 1'b0;
      filter_en <= 1'b0;
      dbl <= 1'b0;
      rx_en <= 1'b0;
      tx_en <= 1'b0;
      size2 <= 1'b0;
      tx9 <= 1'b0;
      fmt <= FMT_RESET;
      baud_div <= 12'h000;
      baud_cnt <= 12'h000;
      RDATA_O <= 8'h00;
    end else if (CE_I) begin
      fifo_mem <= next_fifo_mem;
      rx_count <= next_rx_count;
      rd_ptr <= next_rd_ptr;
      overrun <= next_overrun;
      filter_en <= next_filter_en;
      dbl <= next_dbl;
      rx_en <= next_rx_en;
      tx_en <= next_tx_en;
      size2 <= next_size2;
      tx9 <= next_tx9;
      fmt <= next_fmt;
      baud_div <= next_baud_div;
      baud_cnt <= next_baud_cnt;
      RDATA_O <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  logic next_tx_valid, next_tx_done, load, bit_end;
  logic [8:0] tx_buf, next_tx_buf;
  logic [12:0] tx_frame, next_tx_frame, built;
  logic [3:0] tx_left, next_tx_left;
  logic [4:0] tx_tc, next_tx_tc;
  // filter enable is not an input here: the sender is never filtered
  assign load = tx_en && tx_valid && tx_left == 4'h0;
  assign bit_end = tick && tx_left != 4'h0 && tx_tc == spb - 5'h01;
  always_comb begin
    built = 13'h1FFE;
    for (int i = 0; i < 9; i++) begin
      if (i < nb) begin
        built[i + 1] = tx_buf[i];
      end
    end
    if (fmt[FM_PAR_EN]) begin
      built[nb + 4'h1] = ^(tx_buf & ~(9'h1FF << nb)) ^ fmt[FM_PAR_ODD];
    end
  end
  always_comb begin
    next_tx_valid = tx_valid;
    next_tx_buf = tx_buf;
    next_tx_frame = tx_frame;
    next_tx_left = tx_left;
    next_tx_tc = tx_tc;
    next_tx_done = tx_done;
    if (WR_I && ADDR_I == OFS_STAT && WDATA_I[ST_TX_DONE]) begin
      next_tx_done = 1'b0;
    end
    if (load) begin
      next_tx_frame = built;
      next_tx_left = 4'h2 + nb + {3'h0, fmt[FM_PAR_EN]} + {3'h0, fmt[FM_STOP2]};
      next_tx_tc = 5'h00;
      next_tx_valid = 1'b0;
    end else if (tick && tx_left != 4'h0) begin
      next_tx_tc = bit_end ? 5'h00 : tx_tc + 5'h01;
      if (bit_end) begin
        next_tx_frame = {1'b1, tx_frame[12:1]};
        next_tx_left = tx_left - 4'h1;
        // set wins over a clear in the same cycle
        if (tx_left == 4'h1 && !tx_valid) begin
          next_tx_done = 1'b1;
        end
      end
    end
    // a write while the buffer is full leaves pending data alone
    if (wr_data && !tx_valid) begin
      next_tx_valid = 1'b1;
      next_tx_buf = {tx9, WDATA_I};
    end
  end
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      tx_valid <= 1'b0;
      tx_buf <= 9'h000;
      tx_frame <= 13'h1FFF;
      tx_left <= 4'h0;
      tx_tc <= 5'h00;
      tx_done <= 1'b0;
    end else if (CE_I) begin
      tx_valid <= next_tx_valid;
      tx_buf <= next_tx_buf;
      tx_frame <= next_tx_frame;
      tx_left <= next_tx_left;
      tx_tc <= next_tx_tc;
      tx_done <= next_tx_done;
    end
  end
  assign SERIAL_OUT_PIN_O = tx_frame[0];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  property p_drop;
    CE_I && drop && !pop && rx_en |=> $stable(rx_count) && $stable(overrun);
  endproperty
  a_drop: assert property (p_drop) else $error("data frame not dropped");
  property p_accept;
    CE_I && rx_end && filter_en && rx_type && rx_count == 2'h0 && !pop && rx_en
      |=> rx_count == 2'h1;
  endproperty
  a_accept: assert property (p_accept) else $error("address frame lost");
  property p_type;
    CE_I && rx_end && !nine && filter_en && !maj && rx_en |=> $stable(rx_count);
  endproperty
  a_type: assert property (p_type) else $error("stop bit type ignored");
  property p_wr_ok;
    CE_I && wr_data && !tx_valid |=> tx_valid && tx_buf[7:0] == $past(WDATA_I);
  endproperty
  a_wr_ok: assert property (p_wr_ok) else $error("write not buffered");
  property p_wr_full;
    CE_I && wr_data && tx_valid && !load |=> $stable(tx_buf) && tx_valid;
  endproperty
  a_wr_full: assert property (p_wr_full) else $error("full buffer changed");
  property p_start;
    CE_I && load |=> !SERIAL_OUT_PIN_O && !tx_valid;
  endproperty
  a_start: assert property (p_start) else $error("no start bit");
  property p_pop;
    CE_I && do_pop && !push && rx_en |=> rx_count == $past(rx_count) - 2'h1;
  endproperty
  a_pop: assert property (p_pop) else $error("read did not pop");
  property p_smp;
    rx_state != RX_IDLE |-> rx_smp >= 5'h01 && rx_smp <= spb;
  endproperty
  a_smp: assert property (p_smp) else $error("sample count out of range");
  property p_vote;
    CE_I && rx_en && tick && rx_state == RX_START && rx_smp == vlast && maj
      |=> rx_state == RX_IDLE;
  endproperty
  a_vote: assert property (p_vote) else $error("noise start accepted");
  property p_done;
    CE_I && RD_I && ADDR_I == OFS_STAT
      |=> RDATA_O[ST_RX_DONE] == ($past(rx_count) != 2'h0)
        && RDATA_O[ST_TX_EMPTY] == !$past(tx_valid);
  endproperty
  a_done: assert property (p_done) else $error("status flag wrong");
  property p_short;
    rx_count != 2'h0 && !nine |-> head[8] == 1'b0;
  endproperty
  a_short: assert property (p_short) else $error("upper bit not zero");
  c_drop: cover property (CE_I && drop);
  c_addr: cover property (CE_I && rx_end && filter_en && rx_type);
  c_load: cover property (CE_I && load);
  c_full: cover property (CE_I && rx_count == 2'h2 && rx_end);
endmodule
`default_nettype wire

// ---- bench/uafd_node.sv ----
// Purpose: far serial node on the shared line, sends frames and captures frames
// Assumes: line idles high, bit time counted in system clocks per bit
// Notes: always sends two stop bits so the first one can carry the frame type
`timescale 1ns/100ps
`default_nettype none
module uafd_node (
  input wire logic clk_i,
  input wire logic line_i,
  output logic line_o
);
  int nb = 8;
  int cpb = 16;
  logic [9:0] cap_q[$];
  logic [9:0] word;

  initial begin
    line_o = 1'b1;
  end

  // ----------------------------------------------------------------
  // sender
  // ----------------------------------------------------------------
  // ninth bit or first stop bit carries the frame type
  // the second stop bit is always sent, so the frame still ends high
  task automatic send(input logic [8:0] d, input logic ftype);
    logic v;
    @(posedge clk_i);
    for (int i = 0; i <= nb + 2; i++) begin
      if (i == 0) begin
        v = 1'b0;
      end else if (i <= nb) begin
        v = d[i-1];
      end else if (i == nb + 1) begin
        v = ftype;
      end else begin
        v = 1'b1;
      end
      line_o <= v;
      repeat (cpb) @(posedge clk_i);
    end
  endtask

  // ----------------------------------------------------------------
  // capture: samples bit centres, stores data bits plus the stop bit
  // ----------------------------------------------------------------
  // the stop bit lands at position nb, so a wrong length shows up as a bad stop
  always begin
    @(posedge clk_i);
    if (line_i === 1'b0) begin
      word = 10'h000;
      repeat (cpb / 2) @(posedge clk_i);
      for (int i = 0; i <= nb; i++) begin
        repeat (cpb) @(posedge clk_i);
        word[i] = line_i;
      end
      cap_q.push_back(word);
    end
  end
endmodule
`default_nettype wire

// ---- bench/tb_uart_address_filter_data_port.sv ----
// Purpose: register level test of the filtering serial port against a serial node
// Assumes: baud divisor 0 gives one sample tick per clock
// Notes: software side rules are kept by the order of the calls below
`timescale 1ns/100ps
`default_nettype none
module tb_uart_address_filter_data_port;
  import uafd_pkg::*;
  logic CLK_SYS_I;
  logic RST_I;
  logic CE_I;
  logic [2:0] ADDR_I;
  logic [7:0] WDATA_I;
  logic WR_I;
  logic RD_I;
  logic [7:0] RDATA_O;
  logic SERIAL_OUT_PIN_O;
  logic line_in;
  int bad_count;
  int cmp_count;

  uafd_top uut (
    .CLK_SYS_I(CLK_SYS_I),
    .RST_I(RST_I),
    .CE_I(CE_I),
    .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I),
    .WR_I(WR_I),
    .RD_I(RD_I),
    .SERIAL_IN_PIN_I(line_in),
    .RDATA_O(RDATA_O),
    .SERIAL_OUT_PIN_O(SERIAL_OUT_PIN_O)
  );

  uafd_node node (
    .clk_i(CLK_SYS_I),
    .line_i(SERIAL_OUT_PIN_O),
    .line_o(line_in)
  );

  initial begin
    CLK_SYS_I = 1'b0;
    forever #50 CLK_SYS_I = ~CLK_SYS_I;
  end

  // ----------------------------------------------------------------
  // access tasks and compares
  // ----------------------------------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge CLK_SYS_I);
    ADDR_I <= a;
    WDATA_I <= d;
    WR_I <= 1'b1;
    @(posedge CLK_SYS_I);
    WR_I <= 1'b0;
  endtask

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk10(input string what, input logic [9:0] exp, input logic [9:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [2:0] a, input logic [7:0] exp, input string what);
    logic [7:0] got;
    @(posedge CLK_SYS_I);
    ADDR_I <= a;
    RD_I <= 1'b1;
    @(posedge CLK_SYS_I);
    RD_I <= 1'b0;
    #1;
    got = RDATA_O;
    chk8(what, exp, got);
  endtask

  // a frame is queued at the stop vote, well before the second stop ends
  task automatic xmit(input logic [8:0] d, input logic ftype);
    node.send(d, ftype);
    repeat (6) @(posedge CLK_SYS_I);
  endtask

  task automatic txchk(input logic [9:0] exp);
    logic [9:0] got;
    int n;
    n = 0;
    while (node.cap_q.size() == 0 && n < 4000) begin
      @(posedge CLK_SYS_I);
      n++;
    end
    got = (node.cap_q.size() > 0) ? node.cap_q.pop_front() : ~exp;
    chk10("tx frame", exp, got);
  endtask

  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (50000) @(posedge CLK_SYS_I);
    bad_count++;
    close_out();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    RST_I = 1'b1;
    CE_I = 1'b1;
    ADDR_I = 3'h0;
    WDATA_I = 8'h00;
    WR_I = 1'b0;
    RD_I = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    repeat (20) @(posedge CLK_SYS_I);
    RST_I <= 1'b0;
    rchk(OFS_STAT, 8'h20, "status after reset");
    rchk(OFS_FMT, FMT_RESET, "format after reset");
    wr(3'h7, 8'hff);
    rchk(3'h7, 8'h00, "unmapped index");
    // nine bit frames, filter on: data frame dropped, address frame taken
    wr(OFS_CTRL, 8'h1c);
    wr(OFS_STAT, 8'h01);
    node.nb = 9;
    xmit(9'h033, 1'b1);
    rchk(OFS_STAT, 8'h21, "status after data frame");
    xmit(9'h15a, 1'b1);
    rchk(OFS_STAT, 8'ha1, "status after address frame");
    rchk(OFS_CTRL, 8'h1e, "rx ninth bit");
    rchk(OFS_DATA, 8'h5a, "address byte");
    rchk(OFS_STAT, 8'h20 | 8'h01, "status after pop");
    // selected: filter off, two frames queue in order
    wr(OFS_STAT, 8'h00);
    xmit(9'h011, 1'b1);
    xmit(9'h022, 1'b1);
    rchk(OFS_CTRL, 8'h1c, "rx ninth bit data");
    rchk(OFS_DATA, 8'h11, "queue head");
    rchk(OFS_DATA, 8'h22, "queue second");
    rchk(OFS_STAT, 8'h20, "status empty queue");
    xmit(9'h001, 1'b1);
    xmit(9'h002, 1'b1);
    xmit(9'h003, 1'b1);
    rchk(OFS_STAT, 8'ha8, "status full queue");
    rchk(OFS_DATA, 8'h01, "full queue head");
    rchk(OFS_DATA, 8'h02, "full queue second");
    rchk(OFS_STAT, 8'h20, "status after drain");
    // eight bit frames, filter on: first stop bit is the type
    wr(OFS_CTRL, 8'h18);
    wr(OFS_STAT, 8'h01);
    node.nb = 8;
    xmit(9'h077, 1'b0);
    rchk(OFS_STAT, 8'h21, "status after low stop");
    xmit(9'h099, 1'b1);
    rchk(OFS_STAT, 8'ha1, "status after high stop");
    rchk(OFS_DATA, 8'h99, "eight bit address");
    // five bit frames: upper bits dropped both ways
    wr(OFS_STAT, 8'h00);
    wr(OFS_FMT, 8'h00);
    node.nb = 5;
    xmit(9'h015, 1'b1);
    rchk(OFS_DATA, 8'h15, "five bit read");
    wr(OFS_DATA, 8'hc5);
    txchk(10'h025);
    // transmitter held off: second write refused, filter has no effect on tx
    repeat (40) @(posedge CLK_SYS_I);
    wr(OFS_FMT, 8'h06);
    wr(OFS_CTRL, 8'h10);
    wr(OFS_STAT, 8'h41);
    node.nb = 8;
    wr(OFS_DATA, 8'ha5);
    rchk(OFS_STAT, 8'h01, "status buffer full");
    wr(OFS_DATA, 8'h3c);
    wr(OFS_CTRL, 8'h18);
    txchk(10'h1a5);
    repeat (400) @(posedge CLK_SYS_I);
    chk10("extra frames", 10'h000, 10'(node.cap_q.size()));
    rchk(OFS_STAT, 8'h61, "status tx done");
    // double speed: eight samples per bit
    wr(OFS_STAT, 8'h02);
    node.cpb = 8;
    xmit(9'h0c3, 1'b1);
    rchk(OFS_DATA, 8'hc3, "double speed read");
    // nine bit frame: ninth bit set before the data word
    wr(OFS_CTRL, 8'h1d);
    node.nb = 9;
    wr(OFS_DATA, 8'h5e);
    txchk(10'h35e);
    wr(OFS_CTRL, 8'h18);
    node.nb = 8;
    // divisor 4 gives 80 clocks a bit; sender off by about 1.25 percent
    wr(OFS_STAT, 8'h00);
    wr(OFS_BAUD_LO, 8'h04);
    wr(OFS_BAUD_HI, 8'h00);
    rchk(OFS_BAUD_LO, 8'h04, "baud low");
    // clock enable low: a write must leave no trace
    @(posedge CLK_SYS_I);
    CE_I <= 1'b0;
    wr(OFS_BAUD_LO, 8'h09);
    CE_I <= 1'b1;
    rchk(OFS_BAUD_LO, 8'h04, "write while frozen");
    for (int k = 0; k < 2; k++) begin
      node.cpb = 79 + 2 * k;
      xmit(9'h096, 1'b1);
      rchk(OFS_DATA, 8'h96, "off rate read");
    end
    // receiver off flushes a waiting frame
    xmit(9'h096, 1'b1);
    wr(OFS_CTRL, 8'h08);
    rchk(OFS_STAT, 8'h60, "status after rx off");
    close_out();
  end
endmodule
`default_nettype wire
